// [hdl/fcs_regs.svh]
// offsets, fields, keys, opcodes and timing units of the flash sequencer
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH
// internal flash window (1 MB) where the page latch aliases
`define FCS_FLASH_BASE 32'h0010_0000
`define FCS_FLASH_MASK 32'hFFF0_0000
// device register addresses
`define FCS_FMR_ADDR 32'hFFFF_FF60
`define FCS_FCR_ADDR 32'hFFFF_FF64
`define FCS_FSR_ADDR 32'hFFFF_FF68
// mode register implemented bits, reset value and fields
`define FCS_FMR_MASK 32'h00FF_038D
`define FCS_FMR_RST 32'h0000_0000
`define FCS_FMR_IE_RDY 0
`define FCS_FMR_IE_LOCK_ERROR_FLAG 2
`define FCS_FMR_IE_PROGRAMMING_ERROR_FLAG 3
`define FCS_FMR_NO_ERASE_BEFORE_PROGRAM 7
`define FCS_FMR_MICROSECOND_CYCLE_COUNT_LO 16
// command register fields
`define FCS_KEY 8'h5A
`define FCS_KEY_LO 24
`define FCS_PAGE_LO 8
// status register bit positions
`define FCS_FSR_RDY 0
`define FCS_FSR_LOCK_ERROR_FLAG 2
`define FCS_FSR_PROGRAMMING_ERROR_FLAG 3
`define FCS_FSR_SEC 4
`define FCS_FSR_GP_LO 8
`define FCS_FSR_LOCKS_LO 16
// opcodes
`define FCS_OP_NONE 4'h0
`define FCS_OP_WP 4'h1
`define FCS_OP_SLB 4'h2
`define FCS_OP_WPL 4'h3
`define FCS_OP_CLB 4'h4
`define FCS_OP_EA 4'h8
`define FCS_OP_SET_GENERAL_BIT_CMD 4'hB
`define FCS_OP_CLEAR_GENERAL_BIT_CMD 4'hD
`define FCS_OP_SSB 4'hF
// array organisation
`define FCS_GP_NUM 3
`define FCS_REGION_LO 6
// operation lengths in units of the microsecond cycle count
`define FCS_PERASE_UNITS 2000
`define FCS_PROG_UNITS 2000
`define FCS_EALL_UNITS 10000
`define FCS_NVM_UNITS 1000
// host-side register offsets
`define FCS_H_CMD 8'h00
`define FCS_H_MODE 8'h04
`define FCS_H_LATCH 8'h08
`define FCS_H_POLL 8'h0C
`define FCS_H_CTRL 8'h10
`endif

// [hdl/fcs_pkg.sv]
// types shared by both ends of the flash sequencer
`include "fcs_regs.svh"
package fcs_pkg;
	typedef logic [31:0] fcs_word_t;
	typedef logic [9:0] fcs_page_t;
	typedef logic [5:0] fcs_widx_t;
	typedef logic [7:0] fcs_haddr_t;
	typedef logic [23:0] fcs_cnt_t;
	// sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_PERASE = 5'b00010,
		ST_PROG = 5'b00100,
		ST_NVM = 5'b01000,
		ST_EALL = 5'b10000
	} fcs_state_e;
endpackage

// [hdl/fcs_bus_if.sv]
// bus and side wires joining processor end and flash controller end
`timescale 1ns/100ps
`include "fcs_regs.svh"
interface fcs_bus_if;
	logic [31:0] addr; // byte address
	logic [31:0] wdata; // write data
	logic wr; // write strobe
	logic rd; // read strobe
	logic [31:0] rdata; // read data, cycle after rd
	logic irq; // controller interrupt line
	logic erase_req; // external hardware erase level
	modport dev (input addr, wdata, wr, rd, erase_req, output rdata, irq);
	modport host (output addr, wdata, wr, rd, erase_req, input rdata, irq);
endinterface

// [hdl/fcs_host.sv]
// processor-side end: turns software orders into bus cycles
`timescale 1ns/100ps
`include "fcs_regs.svh"
module fcs_host (
	// clock, reset, freeze
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ce,
	// link to the flash controller
	fcs_bus_if.host bus,
	// software port
	input wire fcs_pkg::fcs_haddr_t sw_addr,
	input wire fcs_pkg::fcs_word_t sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output fcs_pkg::fcs_word_t sw_rdata
);
	import fcs_pkg::*;

	logic bwr_q; // bus write strobe
	logic brd_q; // bus read strobe
	fcs_word_t baddr_q; // bus address
	fcs_word_t bwdata_q; // bus write data
	fcs_widx_t ptr_q; // next latch word
	logic poll_q; // status read data due now
	fcs_word_t stat_q; // last status seen
	logic erase_q; // external erase level
	fcs_word_t rdata_q; // software read data

	assign bus.wr = bwr_q;
	assign bus.rd = brd_q;
	assign bus.addr = baddr_q;
	assign bus.wdata = bwdata_q;
	assign bus.erase_req = erase_q;
	assign sw_rdata = rdata_q;

	// one bus cycle for each software write to the command, mode, latch or poll offset, issued on the next edge
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			bwr_q <= 1'b0;
			brd_q <= 1'b0;
			baddr_q <= 32'h0000_0000;
			bwdata_q <= 32'h0000_0000;
		end else if (ce) begin
			bwr_q <= 1'b0;
			brd_q <= 1'b0;
			if (sw_wr) begin
				case (sw_addr)
					`FCS_H_CMD: begin
						// key added here, never left to software
						bwr_q <= 1'b1;
						baddr_q <= `FCS_FCR_ADDR;
						bwdata_q <= {`FCS_KEY, sw_wdata[23:0]};
					end
					`FCS_H_MODE: begin
						bwr_q <= 1'b1;
						baddr_q <= `FCS_FMR_ADDR;
						bwdata_q <= sw_wdata;
					end
					`FCS_H_LATCH: begin
						// whole aligned words only
						bwr_q <= 1'b1;
						baddr_q <= `FCS_FLASH_BASE | {24'h00_0000, ptr_q, 2'b00};
						bwdata_q <= sw_wdata;
					end
					`FCS_H_POLL: begin
						brd_q <= 1'b1;
						baddr_q <= `FCS_FSR_ADDR;
					end
					default: begin
						bwr_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// latch word pointer, restarts when a command goes out
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ptr_q <= 6'h00;
		end else if (ce && sw_wr) begin
			if (sw_addr == `FCS_H_LATCH) begin
				ptr_q <= ptr_q + 6'h01;
			end else if (sw_addr == `FCS_H_CMD) begin
				ptr_q <= 6'h00;
			end
		end
	end

	// capture status word one cycle after the read strobe
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			poll_q <= 1'b0;
			stat_q <= 32'h0000_0000;
		end else if (ce) begin
			poll_q <= brd_q;
			if (poll_q) begin
				stat_q <= bus.rdata;
			end
		end
	end

	// erase level and software read data
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			erase_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else if (ce) begin
			if (sw_wr && sw_addr == `FCS_H_CTRL) begin
				erase_q <= sw_wdata[0];
			end
			rdata_q <= 32'h0000_0000;
			if (sw_rd) begin
				case (sw_addr)
					`FCS_H_POLL: rdata_q <= stat_q;
					`FCS_H_CTRL: rdata_q <= {22'h00_0000, ptr_q, 2'b00, bus.irq, erase_q};
					default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// [hdl/fcs_device.sv]
// flash controller end: page latch, command sequencer, lock and nvm bits
`timescale 1ns/100ps
`include "fcs_regs.svh"
// Notes on behaviour
// - master updates pages in aligned words
// - write-and-lock programs, then locks region
// - page latch aliases over whole flash
// - master never writes bytes or halfwords
// - master fills whole page before command
// - valid command starts, ready drops
// - completion raises ready and maybe interrupt
// - bad key or opcode flags error
// - write into locked region flags error
// - erase-all with locks refused, lock error
// - refused erase-all erases nothing
// - lock commands carry key and page
// - lock bits can be cleared again
// - stored lock bit inverse of status
// - reads allowed during nvm bit commands
// - out-of-range general bit does nothing
// - general bits set and clear individually
// - security bit blocks debug until external erase
// - external erase clears all, security in the same cycle
// - set-security raises ready, status shows it
// - opcode encodings shared by both ends
// - status read clears both error flags
// - page erased first unless no-erase set
module fcs_device #(
	parameter int unsigned PERASE_UNITS = `FCS_PERASE_UNITS,
	parameter int unsigned PROG_UNITS = `FCS_PROG_UNITS,
	parameter int unsigned EALL_UNITS = `FCS_EALL_UNITS,
	parameter int unsigned NVM_UNITS = `FCS_NVM_UNITS
) (
	// clock, reset, freeze
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ce,
	// link from the processor end
	fcs_bus_if.dev bus,
	// flash array control
	output fcs_pkg::fcs_page_t arr_page,
	output logic arr_erase_page,
	output logic arr_prog_page,
	output logic arr_erase_all,
	input wire fcs_pkg::fcs_widx_t arr_word_idx,
	output fcs_pkg::fcs_word_t arr_word,
	// read_ok from the sequencer state, side effects of stored bits
	output logic read_ok,
	output logic debug_block,
	output logic [2:0] gp_bits
);
	import fcs_pkg::*;

	// operation length in cycles, minus one; zero count taken as one
	function automatic fcs_cnt_t dur(input logic [7:0] mc,
		input int unsigned units);
		logic [31:0] m;
		m = (mc == 8'h00) ? 32'h0000_0001 : {24'h00_0000, mc};
		return fcs_cnt_t'(m * units - 32'h0000_0001);
	endfunction

	fcs_word_t latch_q [64]; // page latch
	fcs_word_t fmr_q; // mode register
	logic ready_flag_q; // ready flag
	logic lock_error_flag_q; // lock error flag
	logic programming_error_flag_q; // programming error flag
	logic sec_q; // security bit
	logic [15:0] lock_q; // stored lock bits, 1 = unlocked
	logic [2:0] gp_q; // general bits
	fcs_state_e st_q; // sequencer state
	logic [3:0] op_q; // running opcode
	fcs_page_t page_q; // running page
	fcs_cnt_t cnt_q; // cycles left in the step
	logic ext_q; // erase came from the pin
	fcs_word_t rdata_q; // bus read data
	fcs_word_t word_q; // latch word to the array
	logic pe_q, pp_q, ea_q; // array pulses

	logic [7:0] microsecond_cycle_count; // microsecond cycle count
	logic [3:0] opc; // opcode field of a command write
	fcs_page_t pg; // page field of a command write
	logic fcr_wr, fsr_rd, idle, done, op_ok, key_ok;
	logic lock_hit, ea_hit, gp_bad, go, start, cmd_err;
	fcs_word_t fsr_val; // status word

	assign microsecond_cycle_count = fmr_q[`FCS_FMR_MICROSECOND_CYCLE_COUNT_LO +: 8];
	assign opc = bus.wdata[3:0];
	assign pg = bus.wdata[`FCS_PAGE_LO +: 10];
	assign fcr_wr = bus.wr && (bus.addr == `FCS_FCR_ADDR);
	assign fsr_rd = bus.rd && (bus.addr == `FCS_FSR_ADDR);
	assign idle = (st_q == ST_IDLE);
	assign done = !idle && (cnt_q == 24'h00_0000);
	assign key_ok = (bus.wdata[`FCS_KEY_LO +: 8] == `FCS_KEY);

	// opcode validity
	always_comb begin
		case (opc)
			`FCS_OP_WP, `FCS_OP_SLB, `FCS_OP_WPL, `FCS_OP_CLB,
			`FCS_OP_EA, `FCS_OP_SET_GENERAL_BIT_CMD, `FCS_OP_CLEAR_GENERAL_BIT_CMD,
			`FCS_OP_SSB: op_ok = 1'b1;
			default: op_ok = 1'b0;
		endcase
	end

	// command checks, taken in the cycle of the register write
	assign go = fcr_wr && key_ok && op_ok && idle && !bus.erase_req;
	assign lock_hit = (opc == `FCS_OP_WP || opc == `FCS_OP_WPL)
		&& !lock_q[pg[9:`FCS_REGION_LO]];
	assign ea_hit = (opc == `FCS_OP_EA) && (lock_q != 16'hFFFF);
	assign gp_bad = (opc == `FCS_OP_SET_GENERAL_BIT_CMD || opc == `FCS_OP_CLEAR_GENERAL_BIT_CMD)
		&& (pg >= 10'(`FCS_GP_NUM));
	assign start = go && !lock_hit && !ea_hit && !gp_bad;
	assign cmd_err = fcr_wr && (!key_ok || (!op_ok && opc != `FCS_OP_NONE)
		|| !idle || bus.erase_req);

	// status word, lock status is the inverse of the stored bit
	assign fsr_val = {~lock_q, 5'b0_0000, gp_q, 3'b000, sec_q, programming_error_flag_q,
		lock_error_flag_q, 1'b0, ready_flag_q};

	// interrupt line and side outputs
	assign bus.irq = (ready_flag_q && fmr_q[`FCS_FMR_IE_RDY])
		|| (lock_error_flag_q && fmr_q[`FCS_FMR_IE_LOCK_ERROR_FLAG])
		|| (programming_error_flag_q && fmr_q[`FCS_FMR_IE_PROGRAMMING_ERROR_FLAG]);
	assign read_ok = idle || (st_q == ST_NVM);
	assign debug_block = sec_q;
	assign gp_bits = gp_q;
	assign bus.rdata = rdata_q;
	assign arr_page = page_q;
	assign arr_erase_page = pe_q;
	assign arr_prog_page = pp_q;
	assign arr_erase_all = ea_q;
	assign arr_word = word_q;

	// page latch: low eight address bits only, so it repeats per page
	always_ff @(posedge sys_clk) begin
		if (ce && bus.wr
			&& ((bus.addr & `FCS_FLASH_MASK) == `FCS_FLASH_BASE)) begin
			latch_q[bus.addr[7:2]] <= bus.wdata;
		end
	end

	// latch word handed to the array
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			word_q <= 32'h0000_0000;
		end else if (ce) begin
			word_q <= latch_q[arr_word_idx];
		end
	end

	// mode register and bus read data
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			fmr_q <= `FCS_FMR_RST;
			rdata_q <= 32'h0000_0000;
		end else if (ce) begin
			if (bus.wr && bus.addr == `FCS_FMR_ADDR) begin
				fmr_q <= bus.wdata & `FCS_FMR_MASK;
			end
			rdata_q <= 32'h0000_0000;
			if (bus.rd) begin
				case (bus.addr)
					`FCS_FMR_ADDR: rdata_q <= fmr_q;
					`FCS_FSR_ADDR: rdata_q <= fsr_val;
					default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// sequencer: state, opcode, page and step counter
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			st_q <= ST_IDLE;
			op_q <= `FCS_OP_NONE;
			page_q <= 10'h000;
			cnt_q <= 24'h00_0000;
			ext_q <= 1'b0;
		end else if (ce) begin
			if (!idle && !done) begin
				cnt_q <= cnt_q - 24'h00_0001;
			end
			case (st_q)
				ST_IDLE: begin
					if (bus.erase_req) begin
						st_q <= ST_EALL;
						ext_q <= 1'b1;
						cnt_q <= dur(microsecond_cycle_count, EALL_UNITS);
					end else if (start) begin
						op_q <= opc;
						page_q <= pg;
						ext_q <= 1'b0;
						if (opc == `FCS_OP_WP || opc == `FCS_OP_WPL) begin
							if (fmr_q[`FCS_FMR_NO_ERASE_BEFORE_PROGRAM]) begin
								st_q <= ST_PROG;
								cnt_q <= dur(microsecond_cycle_count, PROG_UNITS);
							end else begin
								st_q <= ST_PERASE;
								cnt_q <= dur(microsecond_cycle_count, PERASE_UNITS);
							end
						end else if (opc == `FCS_OP_EA) begin
							st_q <= ST_EALL;
							cnt_q <= dur(microsecond_cycle_count, EALL_UNITS);
						end else begin
							st_q <= ST_NVM;
							cnt_q <= dur(microsecond_cycle_count, NVM_UNITS);
						end
					end
				end
				ST_PERASE: begin
					if (done) begin
						st_q <= ST_PROG;
						cnt_q <= dur(microsecond_cycle_count, PROG_UNITS);
					end
				end
				ST_PROG: begin
					if (done && op_q == `FCS_OP_WPL) begin
						st_q <= ST_NVM;
						cnt_q <= dur(microsecond_cycle_count, NVM_UNITS);
					end else if (done) begin
						st_q <= ST_IDLE;
					end
				end
				ST_NVM, ST_EALL: begin
					if (done) begin
						st_q <= ST_IDLE;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// one-cycle array strobes at the end of each erase and program step
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pe_q <= 1'b0;
			pp_q <= 1'b0;
			ea_q <= 1'b0;
		end else if (ce) begin
			pe_q <= done && (st_q == ST_PERASE);
			pp_q <= done && (st_q == ST_PROG);
			ea_q <= done && (st_q == ST_EALL);
		end
	end

	// lock, general and security bits, changed as a step ends
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			lock_q <= 16'hFFFF;
			gp_q <= 3'b000;
			sec_q <= 1'b0;
		end else if (ce && done) begin
			if (st_q == ST_EALL && ext_q) begin
				lock_q <= 16'hFFFF;
				gp_q <= 3'b000;
				sec_q <= 1'b0;
			end else if (st_q == ST_NVM) begin
				case (op_q)
					`FCS_OP_SLB, `FCS_OP_WPL:
						lock_q[page_q[9:`FCS_REGION_LO]] <= 1'b0;
					`FCS_OP_CLB:
						lock_q[page_q[9:`FCS_REGION_LO]] <= 1'b1;
					`FCS_OP_SET_GENERAL_BIT_CMD: gp_q[page_q[1:0]] <= 1'b1;
					`FCS_OP_CLEAR_GENERAL_BIT_CMD: gp_q[page_q[1:0]] <= 1'b0;
					`FCS_OP_SSB: sec_q <= 1'b1;
					default: sec_q <= sec_q;
				endcase
			end
		end
	end

	// ready flag: falls on start, rises as the sequence returns to idle
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ready_flag_q <= 1'b1;
		end else if (ce) begin
			if (done && (st_q == ST_NVM || st_q == ST_EALL
				|| (st_q == ST_PROG && op_q != `FCS_OP_WPL))) begin
				ready_flag_q <= 1'b1;
			end else if (idle && (start || bus.erase_req)) begin
				ready_flag_q <= 1'b0;
			end
		end
	end

	// error flags: set wins over the clear by a status read
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			lock_error_flag_q <= 1'b0;
			programming_error_flag_q <= 1'b0;
		end else if (ce) begin
			if (go && (lock_hit || ea_hit)) begin
				lock_error_flag_q <= 1'b1;
			end else if (fsr_rd) begin
				lock_error_flag_q <= 1'b0;
			end
			if (cmd_err) begin
				programming_error_flag_q <= 1'b1;
			end else if (fsr_rd) begin
				programming_error_flag_q <= 1'b0;
			end
		end
	end
endmodule

// [test/fcs_monitor.sv]
// bus checker standing beside the link between the two sequencer ends
`timescale 1ns/100ps
`include "fcs_regs.svh"
module fcs_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// bus wires
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic irq,
	input wire logic erase_req
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic [31:0] mode_q; // shadow of the mode register
	logic fsr_q; // status read answered this cycle
	logic rdy_q; // last status showed ready, no command since
	logic lkv_q; // lock snapshot still valid
	logic [15:0] locks_q; // lock status from last status read
	logic fcr_w, fsr_r, okop, legal, lockhit;
	logic [3:0] op;
	assign op = wdata[3:0];
	assign fcr_w = wr && addr == `FCS_FCR_ADDR;
	assign fsr_r = rd && addr == `FCS_FSR_ADDR;
	// commands whose start never depends on lock state
	assign okop = wdata[31:24] == `FCS_KEY && !erase_req &&
		(op inside {`FCS_OP_SLB, `FCS_OP_CLB, `FCS_OP_SSB} ||
		(op inside {`FCS_OP_SET_GENERAL_BIT_CMD, `FCS_OP_CLEAR_GENERAL_BIT_CMD} && wdata[17:8] < 10'h003));
	assign legal = op inside {`FCS_OP_NONE, `FCS_OP_WP, `FCS_OP_SLB,
		`FCS_OP_WPL, `FCS_OP_CLB, `FCS_OP_EA, `FCS_OP_SET_GENERAL_BIT_CMD, `FCS_OP_CLEAR_GENERAL_BIT_CMD,
		`FCS_OP_SSB};
	// write or erase aimed at locked pages while idle
	assign lockhit = fcr_w && rdy_q && lkv_q && !erase_req &&
		wdata[31:24] == `FCS_KEY && ((op == `FCS_OP_EA && |locks_q) ||
		((op == `FCS_OP_WP || op == `FCS_OP_WPL) && locks_q[wdata[17:14]]));
	// mode shadow follows bus writes
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			mode_q <= 32'h0000_0000;
		end else if (wr && addr == `FCS_FMR_ADDR) begin
			mode_q <= wdata & `FCS_FMR_MASK;
		end
	end
	// answer cycle of a status read
	always_ff @(posedge sys_clk) begin
		fsr_q <= rstn && fsr_r;
	end
	// ready and lock snapshot, dropped by any command or erase
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rdy_q <= 1'b0;
			lkv_q <= 1'b0;
			locks_q <= 16'h0000;
		end else if (fcr_w || erase_req) begin
			rdy_q <= 1'b0;
			lkv_q <= 1'b0;
		end else if (fsr_q) begin
			rdy_q <= rdata[0];
			lkv_q <= 1'b1;
			locks_q <= rdata[31:16];
		end
	end
	property p_key;
		fcr_w |-> wdata[31:24] == `FCS_KEY;
	endproperty
	a_key: assert property (p_key) else $error("command without key");
	property p_word;
		wr && (addr & `FCS_FLASH_MASK) == `FCS_FLASH_BASE |-> addr[1:0] == 2'b00;
	endproperty
	a_word: assert property (p_word) else $error("latch write unaligned");
	property p_err_clear;
		fsr_r ##1 fsr_r |=> rdata[3:2] == 2'b00;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("flags kept");
	property p_irq_rdy;
		fsr_q && rdata[0] && mode_q[0] && !$past(erase_req) |-> irq;
	endproperty
	a_irq_rdy: assert property (p_irq_rdy) else $error("ready irq missing");
	property p_start_busy;
		fcr_w && okop && rdy_q ##1 fsr_r |=> !rdata[0];
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("ready kept");
	property p_bad_op;
		fcr_w && !legal ##1 fsr_r |=> rdata[3];
	endproperty
	a_bad_op: assert property (p_bad_op) else $error("no prog error");
	property p_lock_err;
		lockhit ##1 fsr_r |=> rdata[2] && rdata[0];
	endproperty
	a_lock_err: assert property (p_lock_err) else $error("no lock err");
	property p_lock_irq;
		lockhit && op == `FCS_OP_EA && mode_q[2] |=> irq;
	endproperty
	a_lock_irq: assert property (p_lock_irq) else $error("no lock irq");
	c_start: cover property (fcr_w && okop && rdy_q);
	c_lock: cover property (lockhit ##1 fsr_r);
	c_reads: cover property (fsr_r ##1 fsr_r);
endmodule

// [test/flash_command_sequencer_tb.sv]
// self-checking bench joining processor end and controller end
`timescale 1ns/100ps
`include "fcs_regs.svh"
module flash_command_sequencer_tb;
	import fcs_pkg::*;
	logic sys_clk = 1'b0; // 125 MHz
	logic rstn, ce;
	fcs_haddr_t sw_addr;
	fcs_word_t sw_wdata, sw_rdata, arr_word, lat [64];
	logic sw_wr, sw_rd, arr_erase_page, arr_prog_page, arr_erase_all;
	logic read_ok, debug_block;
	logic [2:0] gp_bits, m_gp; // m_ values model the bits as the status word shows them
	logic [15:0] m_lock;
	logic m_sec;
	fcs_page_t arr_page, pg_q;
	fcs_widx_t arr_word_idx;
	int checked, fail_count, n_er, n_pg, n_ea;
	int cyc, c_er, c_pg; // edge count and edges of the last pulses
	fcs_bus_if fcs_bus_if_i ();
	fcs_host fcs_host_i (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
		.bus(fcs_bus_if_i), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
	// short step lengths keep the run brief
	fcs_device #(.PERASE_UNITS(4), .PROG_UNITS(4), .EALL_UNITS(8),
		.NVM_UNITS(2)) fcs_device_i (.sys_clk(sys_clk), .rstn(rstn),
		.ce(ce), .bus(fcs_bus_if_i), .arr_page(arr_page),
		.arr_erase_page(arr_erase_page), .arr_prog_page(arr_prog_page),
		.arr_erase_all(arr_erase_all), .arr_word_idx(arr_word_idx),
		.arr_word(arr_word), .read_ok(read_ok), .debug_block(debug_block),
		.gp_bits(gp_bits));
	fcs_monitor fcs_monitor_i (.sys_clk(sys_clk), .rstn(rstn),
		.addr(fcs_bus_if_i.addr), .wdata(fcs_bus_if_i.wdata),
		.wr(fcs_bus_if_i.wr), .rd(fcs_bus_if_i.rd),
		.rdata(fcs_bus_if_i.rdata), .irq(fcs_bus_if_i.irq),
		.erase_req(fcs_bus_if_i.erase_req));
	always #4 sys_clk = ~sys_clk;
	// count array pulses and remember the programmed page
	always @(posedge sys_clk) begin
		cyc++;
		if (arr_erase_page === 1'b1) begin
			n_er++;
			c_er = cyc;
		end
		if (arr_erase_all === 1'b1) n_ea++;
		if (arr_prog_page === 1'b1) begin
			n_pg++;
			c_pg = cyc;
			pg_q = arr_page;
		end
	end
	// expected status word, ready high
	function automatic fcs_word_t exp_st(input logic [1:0] err);
		return {m_lock, 5'h00, m_gp, 3'h0, m_sec, err, 1'b0, 1'b1};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	// software write; strobe stays high so writes may follow back to back
	task automatic wr_sw(input fcs_haddr_t a, input fcs_word_t d);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		sw_rd <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic idle();
		sw_wr <= 1'b0;
		sw_rd <= 1'b0;
		@(posedge sys_clk);
	endtask
	// software read, data taken in the answer cycle
	task automatic rd_sw(input fcs_haddr_t a, output fcs_word_t d);
		sw_addr <= a;
		sw_wr <= 1'b0;
		sw_rd <= 1'b1;
		@(posedge sys_clk);
		sw_rd <= 1'b0;
		@(posedge sys_clk);
		d = sw_rdata;
	endtask
	task automatic cmd(input fcs_page_t p, input logic [3:0] o);
		wr_sw(`FCS_H_CMD, {14'h0000, p, 4'h0, o});
	endtask
	// status read through the host, which clears the error flags
	task automatic poll(output fcs_word_t st);
		wr_sw(`FCS_H_POLL, 32'h0000_0000);
		idle();
		idle();
		rd_sw(`FCS_H_POLL, st);
	endtask
	// bounded wait for ready
	task automatic wait_rdy(output fcs_word_t st);
		int n;
		n = 0;
		st = 32'h0000_0000;
		while (st[0] !== 1'b1) begin
			poll(st);
			n++;
			if (n > 300) begin
				fail_count++;
				complete_run();
			end
		end
	endtask
	initial begin
		fcs_word_t st;
		int i, pg, ne, np;
		logic [3:0] op;
		rstn = 1'b0;
		ce = 1'b1;
		sw_addr = 8'h00;
		sw_wdata = 32'h0000_0000;
		sw_wr = 1'b0;
		sw_rd = 1'b0;
		arr_word_idx = 6'h00;
		m_lock = 16'h0000;
		m_gp = 3'h0;
		m_sec = 1'b0;
		void'($urandom(32'h3085));
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		// reset state, then ready interrupt with one cycle unit
		poll(st);
		chk(st, exp_st(2'b00));
		wr_sw(`FCS_H_MODE, 32'h0001_0001);
		poll(st);
		rd_sw(`FCS_H_CTRL, st);
		chk(st[1], 1'b1);
		done("reset");
		// fill the latch with random words; pointer wraps
		for (i = 0; i < 64; i++) begin
			lat[i] = $urandom;
			wr_sw(`FCS_H_LATCH, lat[i]);
			// pointer part way through the fill, before it wraps
			if (i == 40) begin
				rd_sw(`FCS_H_CTRL, st);
				chk(st[9:4], 6'h29);
			end
		end
		rd_sw(`FCS_H_CTRL, st);
		chk(st[9:4], 6'h00);
		for (i = 0; i < 8; i++) begin
			pg = $urandom_range(63);
			arr_word_idx <= pg[5:0];
			idle();
			idle();
			chk(arr_word, lat[pg]);
		end
		done("latch");
		// page 3 with erase, then page 5 without
		ne = n_er;
		np = n_pg;
		cmd(10'h003, `FCS_OP_WP);
		poll(st);
		chk(st[0], 1'b0);
		wait_rdy(st);
		chk(n_er - ne, 1);
		chk(pg_q, 10'h003);
		// program step: four units of one cycle between the two pulses
		chk(c_pg - c_er, 4);
		wr_sw(`FCS_H_MODE, 32'h0001_0081);
		cmd(10'h005, `FCS_OP_WP);
		wait_rdy(st);
		chk(n_er - ne, 1);
		chk(n_pg - np, 2);
		done("program");
		// write and lock, then a refused write into that region
		cmd(10'h046, `FCS_OP_WPL);
		wait_rdy(st);
		m_lock[1] = 1'b1;
		chk(st, exp_st(2'b00));
		np = n_pg;
		cmd(10'h040, `FCS_OP_WP);
		poll(st);
		chk(st, exp_st(2'b01));
		wr_sw(`FCS_H_POLL, 32'h0000_0000);
		poll(st);
		chk(st, exp_st(2'b00));
		chk(n_pg - np, 0);
		done("lock");
		// erase-all refused while locked, lock-error interrupt only
		wr_sw(`FCS_H_MODE, 32'h0001_0084);
		ne = n_ea;
		cmd(10'h000, `FCS_OP_EA);
		idle();
		idle();
		rd_sw(`FCS_H_CTRL, st);
		chk(st[1], 1'b1);
		poll(st);
		chk(st, exp_st(2'b01));
		chk(n_ea - ne, 0);
		rd_sw(`FCS_H_CTRL, st);
		chk(st[1], 1'b0);
		cmd(10'h040, `FCS_OP_CLB);
		wait_rdy(st);
		m_lock[1] = 1'b0;
		chk(st, exp_st(2'b00));
		cmd(10'h000, `FCS_OP_EA);
		wait_rdy(st);
		chk(n_ea - ne, 1);
		done("erase_all");
		// reserved opcodes flag an error, opcode zero does nothing
		for (i = 0; i < 16; i++) begin
			if (!(i inside {0, 1, 2, 3, 4, 8, 11, 13, 15})) begin
				cmd(10'h000, i[3:0]);
				poll(st);
				chk(st, exp_st(2'b10));
			end
		end
		cmd(10'h000, `FCS_OP_NONE);
		poll(st);
		chk(st, exp_st(2'b00));
		done("opcodes");
		// random general bit set and clear, numbers out of range too
		for (i = 0; i < 10; i++) begin
			pg = $urandom_range(4);
			op = $urandom_range(1) ? `FCS_OP_SET_GENERAL_BIT_CMD : `FCS_OP_CLEAR_GENERAL_BIT_CMD;
			cmd(pg[9:0], op);
			idle();
			// second edge: an in-range bit step is running by now
			idle();
			chk(read_ok, 1'b1);
			wait_rdy(st);
			if (pg < 3) m_gp[pg] = (op == `FCS_OP_SET_GENERAL_BIT_CMD);
			chk(st, exp_st(2'b00));
			chk(gp_bits, m_gp);
		end
		done("general_bits");
		// security bit, then external erase clears everything
		cmd(10'h000, `FCS_OP_SSB);
		poll(st);
		chk(st[0], 1'b0);
		wait_rdy(st);
		m_sec = 1'b1;
		chk(st, exp_st(2'b00));
		chk(debug_block, 1'b1);
		cmd(10'h000, `FCS_OP_SLB);
		wait_rdy(st);
		m_lock[0] = 1'b1;
		chk(st, exp_st(2'b00));
		ne = n_ea;
		wr_sw(`FCS_H_CTRL, 32'h0000_0001);
		wr_sw(`FCS_H_CTRL, 32'h0000_0000);
		idle();
		poll(st);
		chk(st[4:0], 5'h10);
		wait_rdy(st);
		m_lock = 16'h0000;
		m_gp = 3'h0;
		m_sec = 1'b0;
		chk(st, exp_st(2'b00));
		chk(n_ea - ne, 1);
		chk(debug_block, 1'b0);
		done("security");
		complete_run();
	end
endmodule
